// >>> hqd_defines.svh
`ifndef HQD_DEFINES_SVH
`define HQD_DEFINES_SVH

// Parameter addresses
`define HQD_OFS_QS_RAMP    16'h0624
`define HQD_OFS_HALT_SEL   16'h062e
`define HQD_OFS_QS_SEL     16'h0630
`define HQD_OFS_QS_CUR     16'h110a
`define HQD_OFS_HALT_CUR   16'h110c

// Halt reaction codes
`define HQD_HALT_DECEL     16'h0001
`define HQD_HALT_TORQUE    16'h0003
`define HQD_HALT_SEL_RST   16'h0003

// Quick stop reaction codes, signed 16 bit
`define HQD_QS_TORQUE_FLT  16'hfffe
`define HQD_QS_DECEL_FLT   16'hffff
`define HQD_QS_DECEL_QSA   16'h0006
`define HQD_QS_TORQUE_QSA  16'h0007
`define HQD_QS_SEL_RST     16'h0007

// Quick stop ramp in RPM/s
`define HQD_QS_RAMP_RST    32'h00001770
`define HQD_QS_RAMP_MIN    32'h000000c8
`define HQD_QS_RAMP_MAX    32'h002dc6c0

// Error classes that start a quick stop
`define HQD_ERR_CLASS1     3'h1
`define HQD_ERR_CLASS2     3'h2

// Operating state codes shown after a quick stop
`define HQD_OPST_NONE      4'h0
`define HQD_OPST_QS_ACTIVE 4'h7
`define HQD_OPST_FAULT     4'h9

`endif

// >>> hqd_pkg.sv
`default_nettype none
package hqd_pkg;

  // Stop sequencer states
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_HALT_DECEL = 3'b001,
    ST_HALT_HOLD  = 3'b010,
    ST_QS_DECEL   = 3'b011,
    ST_QS_HOLD    = 3'b100,
    ST_FAULT      = 3'b101
  } hqd_mode_type;

  // State of the main block
  typedef struct packed {
    hqd_mode_type mode;
    logic [15:0]  halt_sel;
    logic [15:0]  qs_sel;
    logic [31:0]  qs_ramp;
    logic [31:0]  qs_ramp_act;
    logic         ack;
    logic         err;
    logic [31:0]  rdata;
    logic         resume;
    logic         decel_use_ramp;
    logic [31:0]  decel_value;
    logic [15:0]  cur_lim;
  } hqd_main_type;

  // State of one current limit
  typedef struct packed {
    logic        init_done;
    logic [15:0] value;
  } hqd_cur_type;

endpackage : hqd_pkg
`default_nettype wire

// >>> hqd_reaction_decode.sv
`default_nettype none
`include "hqd_defines.svh"
module hqd_reaction_decode
  import hqd_pkg::*;
(
  input  wire logic [15:0] i_code,
  input  wire logic        i_is_qs,
  output logic             o_valid,
  output logic             o_use_ramp,
  output logic             o_to_fault
);

  // Classify one reaction code of either selector
  always_comb begin
    o_valid    = 1'b0;
    o_use_ramp = 1'b0;
    o_to_fault = 1'b0;
    if (i_is_qs) begin
      unique case (i_code)
        `HQD_QS_TORQUE_FLT: begin
          o_valid    = 1'b1;
          o_to_fault = 1'b1;
        end
        `HQD_QS_DECEL_FLT: begin
          o_valid    = 1'b1;
          o_use_ramp = 1'b1;
          o_to_fault = 1'b1;
        end
        `HQD_QS_DECEL_QSA: begin
          o_valid    = 1'b1;
          o_use_ramp = 1'b1;
        end
        `HQD_QS_TORQUE_QSA: begin
          o_valid    = 1'b1;
        end
        default: begin
          o_valid    = 1'b0;
        end
      endcase
    end else begin
      unique case (i_code)
        `HQD_HALT_DECEL: begin
          o_valid    = 1'b1;
          o_use_ramp = 1'b1;
        end
        `HQD_HALT_TORQUE: begin
          o_valid    = 1'b1;
        end
        default: begin
          o_valid    = 1'b0;
        end
      endcase
    end
  end

endmodule : hqd_reaction_decode
`default_nettype wire

// >>> hqd_cur_limit.sv
`default_nettype none
module hqd_cur_limit
  import hqd_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic [15:0] i_motor_imax,
  input  wire logic [15:0] i_stage_imax,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_value,
  output logic      [15:0] o_max
);

  hqd_cur_type s_q;
  hqd_cur_type s_d;

  // Ceiling is the lower of motor and power stage peak current
  assign o_max   = (i_motor_imax < i_stage_imax) ? i_motor_imax
                                                 : i_stage_imax;
  assign o_value = s_q.value;

  // Load default after reset, take legal writes, clamp to the ceiling
  always_comb begin
    s_d = s_q;
    if (!s_q.init_done) begin
      s_d.init_done = 1'b1;
      s_d.value     = o_max;
    end else if (i_wr && (i_wdata <= o_max)) begin
      s_d.value     = i_wdata;
    end else if (s_q.value > o_max) begin
      s_d.value     = o_max;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

endmodule : hqd_cur_limit
`default_nettype wire

// >>> hqd_stop_select.sv
// Functional notes
// RULE1 - Halt code 1 ramp, 3 torque; default 3
// RULE2 - Ramp honoured only with velocity profile modes
// RULE3 - No profile mode: torque ramp always
// RULE4 - Halt ramp reuses profile deceleration value
// RULE5 - Selector and current changes act immediately
// RULE6 - Quick stop by command or class 1/2
// RULE7 - After quick stop: state 7 or 9
// RULE8 - Codes -2 torque, -1 ramp, end Fault
// RULE9 - Codes 6 ramp, 7 torque; stay; default 7
// RULE10 - Quick stop ramp 200..3000000, default 6000
// RULE11 - New quick stop ramp from next movement
// RULE12 - Stop currents unsigned, 0.01 A steps
// RULE13 - Current ceiling and default from motor/stage
// RULE14 - Torque ramp uses its own current limit
// RULE15 - Withdrawn halt: stop, then resume velocity
// RULE16 - Halt by configured input or command
// RULE17 - Quick stop overrides a running halt
`default_nettype none
`include "hqd_defines.svh"
module hqd_stop_select
  import hqd_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Parameter access
  input  wire logic        i_par_wr,
  input  wire logic        i_par_rd,
  input  wire logic [15:0] i_par_addr,
  input  wire logic [31:0] i_par_wdata,
  output logic      [31:0] o_par_rdata,
  output logic             o_par_ack,
  output logic             o_par_err,
  // Stop requests
  input  wire logic        i_halt_in,
  input  wire logic        i_halt_in_en,
  input  wire logic        i_fb_halt,
  input  wire logic        i_fb_qstop,
  input  wire logic        i_err_valid,
  input  wire logic [2:0]  i_err_class,
  input  wire logic        i_qs_leave,
  input  wire logic        i_fault_reset,
  // Drive context
  input  wire logic        i_profile_mode,
  input  wire logic        i_standstill,
  input  wire logic        i_move_start,
  input  wire logic [31:0] i_profile_decel,
  input  wire logic [15:0] i_motor_imax,
  input  wire logic [15:0] i_stage_imax,
  // Stop reaction
  output logic             o_decel_active,
  output logic             o_decel_use_ramp,
  output logic      [31:0] o_decel_value,
  output logic      [15:0] o_current_limit,
  output logic             o_halt_active,
  output logic             o_qs_active,
  output logic             o_resume,
  output logic      [3:0]  o_op_state
);

  localparam hqd_main_type MAIN_RST = '{
    mode:        ST_IDLE,
    halt_sel:    `HQD_HALT_SEL_RST,
    qs_sel:      `HQD_QS_SEL_RST,
    qs_ramp:     `HQD_QS_RAMP_RST,
    qs_ramp_act: `HQD_QS_RAMP_RST,
    default:     '0
  };

  hqd_main_type s_q;
  hqd_main_type s_d;

  logic        halt_req;
  logic        qs_req;
  logic        halt_ramp;
  logic        qs_ramp;
  logic        qs_fault;
  logic        wcode_ok;
  logic        ramp_ok;
  logic        acc;
  logic        wr_halt_cur;
  logic        wr_qs_cur;
  logic [15:0] halt_cur;
  logic [15:0] qs_cur;
  logic [15:0] halt_cur_max;
  logic [15:0] qs_cur_max;

  // Request sources
  assign halt_req = (i_halt_in_en && i_halt_in) || i_fb_halt; // see RULE16
  assign qs_req   = i_fb_qstop ||
                    (i_err_valid && ((i_err_class == `HQD_ERR_CLASS1) ||
                                     (i_err_class == `HQD_ERR_CLASS2)));
                                     // see RULE6

  // Write checks and current limit strobes
  assign acc         = i_par_wr || i_par_rd;
  assign ramp_ok     = (i_par_wdata >= `HQD_QS_RAMP_MIN) &&
                       (i_par_wdata <= `HQD_QS_RAMP_MAX); // see RULE10
  assign wr_halt_cur = i_par_wr && (i_par_addr == `HQD_OFS_HALT_CUR) &&
                       (i_par_wdata[31:16] == 16'h0000);
  assign wr_qs_cur   = i_par_wr && (i_par_addr == `HQD_OFS_QS_CUR) &&
                       (i_par_wdata[31:16] == 16'h0000);

  // Live decode of the halt selector
  hqd_reaction_decode u_halt_dec (
    .i_code     (s_q.halt_sel),
    .i_is_qs    (1'b0),
    .o_valid    (),
    .o_use_ramp (halt_ramp),
    .o_to_fault ()
  );

  // Live decode of the quick stop selector
  hqd_reaction_decode u_qs_dec (
    .i_code     (s_q.qs_sel),
    .i_is_qs    (1'b1),
    .o_valid    (),
    .o_use_ramp (qs_ramp),
    .o_to_fault (qs_fault)
  );

  // Legality of a code being written
  hqd_reaction_decode u_wr_dec (
    .i_code     (i_par_wdata[15:0]),
    .i_is_qs    (i_par_addr == `HQD_OFS_QS_SEL),
    .o_valid    (wcode_ok),
    .o_use_ramp (),
    .o_to_fault ()
  );

  // Halt current limit, 0.01 A steps, ceiling from motor and stage
  hqd_cur_limit u_halt_cur ( // see RULE12 see RULE13
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_ce         (i_ce),
    .i_motor_imax (i_motor_imax),
    .i_stage_imax (i_stage_imax),
    .i_wr         (wr_halt_cur),
    .i_wdata      (i_par_wdata[15:0]),
    .o_value      (halt_cur),
    .o_max        (halt_cur_max)
  );

  // Quick stop current limit
  hqd_cur_limit u_qs_cur ( // see RULE12 see RULE13
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_ce         (i_ce),
    .i_motor_imax (i_motor_imax),
    .i_stage_imax (i_stage_imax),
    .i_wr         (wr_qs_cur),
    .i_wdata      (i_par_wdata[15:0]),
    .o_value      (qs_cur),
    .o_max        (qs_cur_max)
  );

  // Parameter access, stop sequencer and reaction outputs
  always_comb begin
    s_d        = s_q;
    s_d.ack    = acc;
    s_d.err    = 1'b0;
    s_d.resume = 1'b0;
    if (acc) begin
      s_d.rdata = 32'h00000000;
    end
    // Parameter access, write wins when both strobes are high
    if (acc) begin
      unique case (i_par_addr)
        `HQD_OFS_QS_RAMP: begin
          if (i_par_wr) begin
            if (ramp_ok) begin
              s_d.qs_ramp = i_par_wdata;
            end else begin
              s_d.err = 1'b1;
            end
          end else begin
            s_d.rdata = s_q.qs_ramp;
          end
        end
        `HQD_OFS_HALT_SEL: begin
          if (i_par_wr) begin
            if (wcode_ok && (i_par_wdata[31:16] == 16'h0000)) begin
              s_d.halt_sel = i_par_wdata[15:0]; // see RULE1 see RULE5
            end else begin
              s_d.err = 1'b1;
            end
          end else begin
            s_d.rdata = {16'h0000, s_q.halt_sel};
          end
        end
        `HQD_OFS_QS_SEL: begin
          if (i_par_wr) begin
            if (wcode_ok && (i_par_wdata[31:16] == 16'h0000)) begin
              s_d.qs_sel = i_par_wdata[15:0]; // see RULE9 see RULE5
            end else begin
              s_d.err = 1'b1;
            end
          end else begin
            s_d.rdata = {16'h0000, s_q.qs_sel};
          end
        end
        `HQD_OFS_HALT_CUR: begin
          if (i_par_wr) begin
            s_d.err = !wr_halt_cur || (i_par_wdata[15:0] > halt_cur_max);
          end else begin
            s_d.rdata = {16'h0000, halt_cur};
          end
        end
        `HQD_OFS_QS_CUR: begin
          if (i_par_wr) begin
            s_d.err = !wr_qs_cur || (i_par_wdata[15:0] > qs_cur_max);
          end else begin
            s_d.rdata = {16'h0000, qs_cur};
          end
        end
        default: begin
          s_d.err = 1'b1;
        end
      endcase
    end
    // Quick stop ramp is taken over only when a movement starts
    if (i_move_start) begin
      s_d.qs_ramp_act = s_q.qs_ramp; // see RULE11
    end
    // Stop sequencer
    unique case (s_q.mode)
      ST_IDLE: begin
        if (qs_req) begin
          s_d.mode = ST_QS_DECEL; // see RULE6
        end else if (halt_req) begin
          s_d.mode = ST_HALT_DECEL;
        end
      end
      ST_HALT_DECEL: begin
        if (qs_req) begin
          s_d.mode = ST_QS_DECEL; // see RULE17
        end else if (i_standstill) begin
          if (halt_req) begin
            s_d.mode = ST_HALT_HOLD;
          end else begin
            s_d.mode   = ST_IDLE; // see RULE15
            s_d.resume = 1'b1;
          end
        end
      end
      ST_HALT_HOLD: begin
        if (qs_req) begin
          s_d.mode = ST_QS_DECEL;
        end else if (!halt_req) begin
          s_d.mode   = ST_IDLE; // see RULE16
          s_d.resume = 1'b1;
        end
      end
      ST_QS_DECEL: begin
        if (i_standstill) begin
          s_d.mode = qs_fault ? ST_FAULT : ST_QS_HOLD; // see RULE7 see RULE8
        end
      end
      ST_QS_HOLD: begin
        if (i_qs_leave) begin
          s_d.mode = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (i_fault_reset) begin
          s_d.mode = ST_IDLE;
        end
      end
      default: begin
        s_d.mode = ST_IDLE;
      end
    endcase
    // Deceleration method from live settings
    s_d.decel_use_ramp = 1'b0;
    s_d.decel_value    = 32'h00000000;
    s_d.cur_lim        = 16'h0000;
    if (s_q.mode == ST_HALT_DECEL) begin
      s_d.decel_use_ramp = i_profile_mode && halt_ramp; // see RULE2 see RULE3
      s_d.decel_value    = i_profile_decel; // see RULE4
      s_d.cur_lim        = halt_cur; // see RULE14
    end else if (s_q.mode == ST_QS_DECEL) begin
      s_d.decel_use_ramp = i_profile_mode && qs_ramp; // see RULE2 see RULE3
      s_d.decel_value    = s_q.qs_ramp_act; // see RULE10
      s_d.cur_lim        = qs_cur; // see RULE14
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= MAIN_RST;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign o_par_rdata      = s_q.rdata;
  assign o_par_ack        = s_q.ack;
  assign o_par_err        = s_q.err;
  assign o_resume         = s_q.resume;
  assign o_decel_use_ramp = s_q.decel_use_ramp;
  assign o_decel_value    = s_q.decel_value;
  assign o_current_limit  = s_q.cur_lim;
  assign o_decel_active   = (s_q.mode == ST_HALT_DECEL) ||
                            (s_q.mode == ST_QS_DECEL);
  assign o_halt_active    = (s_q.mode == ST_HALT_DECEL) ||
                            (s_q.mode == ST_HALT_HOLD);
  assign o_qs_active      = (s_q.mode == ST_QS_DECEL) ||
                            (s_q.mode == ST_QS_HOLD);
  assign o_op_state       = (s_q.mode == ST_QS_HOLD) ? `HQD_OPST_QS_ACTIVE :
                            (s_q.mode == ST_FAULT)   ? `HQD_OPST_FAULT :
                                                       `HQD_OPST_NONE;

  // Checks
  a_torque_no_profile: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !i_profile_mode && ((s_q.mode == ST_HALT_DECEL) ||
     (s_q.mode == ST_QS_DECEL))) |=> !o_decel_use_ramp) // see RULE3
    else $error("ramp used without velocity profile");

  a_halt_profile_ramp: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_profile_mode && (s_q.mode == ST_HALT_DECEL) &&
     (s_q.halt_sel == `HQD_HALT_DECEL)) |=>
    (o_decel_use_ramp && (o_decel_value == $past(i_profile_decel))))
    // see RULE4
    else $error("halt ramp not the profile deceleration");

  a_halt_cur_use: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && (s_q.mode == ST_HALT_DECEL)) |=>
    (o_current_limit == $past(halt_cur))) // see RULE14
    else $error("halt torque ramp has wrong current");

  a_qs_cur_use: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && (s_q.mode == ST_QS_DECEL)) |=>
    (o_current_limit == $past(qs_cur))) // see RULE14
    else $error("quick stop torque ramp has wrong current");

  a_qs_err_start: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && (s_q.mode == ST_IDLE) && i_err_valid &&
     ((i_err_class == `HQD_ERR_CLASS1) || (i_err_class == `HQD_ERR_CLASS2)))
    |=> (s_q.mode == ST_QS_DECEL) ##1 o_decel_active) // see RULE6
    else $error("error class 1 or 2 did not start quick stop");

  a_qs_over_halt: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && o_halt_active && qs_req) |=> o_qs_active && !o_halt_active)
    // see RULE17
    else $error("quick stop did not override halt");

  a_qs_end_state: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && (s_q.mode == ST_QS_DECEL) && i_standstill) |=>
    (o_op_state == ($past(qs_fault) ? `HQD_OPST_FAULT
                                    : `HQD_OPST_QS_ACTIVE))) // see RULE7
    else $error("wrong state after quick stop standstill");

  a_ramp_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_ce && i_move_start) |=> $stable(s_q.qs_ramp_act)) // see RULE11
    else $error("quick stop ramp changed during movement");

  a_halt_resume: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && (s_q.mode == ST_HALT_DECEL) && i_standstill && !halt_req &&
     !qs_req) |=> (o_resume && !o_halt_active)) // see RULE15
    else $error("withdrawn halt did not resume");

  a_sel_immediate: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_par_wr && (i_par_addr == `HQD_OFS_HALT_SEL) && wcode_ok &&
     (i_par_wdata[31:16] == 16'h0000)) |=>
    (s_q.halt_sel == $past(i_par_wdata[15:0]))) // see RULE5
    else $error("halt selector write not taken at once");

endmodule : hqd_stop_select
`default_nettype wire

// >>> hqd_fb_master.sv
`default_nettype none
// Fieldbus master model: parameter access and stop commands
module hqd_fb_master (
  input  wire logic        i_clk,
  input  wire logic        i_par_ack,
  input  wire logic        i_par_err,
  input  wire logic [31:0] i_par_rdata,
  output logic             o_par_wr,
  output logic             o_par_rd,
  output logic      [15:0] o_par_addr,
  output logic      [31:0] o_par_wdata,
  output logic             o_fb_halt,
  output logic             o_fb_qstop
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    o_par_wr    = 1'b0;
    o_par_rd    = 1'b0;
    o_par_addr  = 16'h0000;
    o_par_wdata = 32'h00000000;
    o_fb_halt   = 1'b0;
    o_fb_qstop  = 1'b0;
  end

  // One access: strobe for one edge, answer taken one edge later
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [31:0] d, output logic ack,
                        output logic err, output logic [31:0] rd);
    @(posedge i_clk);
    o_par_wr    <= w;
    o_par_rd    <= ~w;
    o_par_addr  <= a;
    o_par_wdata <= d;
    @(posedge i_clk);
    o_par_wr    <= 1'b0;
    o_par_rd    <= 1'b0;
    o_par_addr  <= ~a;  // Released lines never keep the last value
    o_par_wdata <= ~d;
    @(posedge i_clk);
    ack = i_par_ack;
    err = i_par_err;
    rd  = i_par_rdata;
  endtask : access

  // Halt command level from the master
  task automatic set_halt(input logic v);
    @(posedge i_clk);
    o_fb_halt <= v;
  endtask : set_halt

  // Quick stop command as a one-cycle pulse
  task automatic quick_stop();
    @(posedge i_clk);
    o_fb_qstop <= 1'b1;
    @(posedge i_clk);
    o_fb_qstop <= 1'b0;
  endtask : quick_stop
endmodule : hqd_fb_master
`default_nettype wire

// >>> hqd_stop_select_tb.sv
`default_nettype none
module hqd_stop_select_tb
  import hqd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic        w;
    logic [15:0] a;
    logic [31:0] d;
    logic        e;
    logic [31:0] rb;
  } hqd_row_type;

  // Parameter rows: reset reads first, then writes with read-back
  hqd_row_type rows [22] = '{
    '{1'b0, 16'h0624, 32'h0, 1'b0, 32'h1770},
    '{1'b0, 16'h062e, 32'h0, 1'b0, 32'h3},
    '{1'b0, 16'h0630, 32'h0, 1'b0, 32'h7},
    '{1'b0, 16'h110a, 32'h0, 1'b0, 32'hc0},
    '{1'b0, 16'h110c, 32'h0, 1'b0, 32'hc0},
    '{1'b1, 16'h062e, 32'h1, 1'b0, 32'h1},
    '{1'b1, 16'h062e, 32'h2, 1'b1, 32'h1},
    '{1'b1, 16'h062e, 32'h3, 1'b0, 32'h3},
    '{1'b1, 16'h062e, 32'h10001, 1'b1, 32'h3},
    '{1'b1, 16'h0630, 32'hfffe, 1'b0, 32'hfffe},
    '{1'b1, 16'h0630, 32'hffff, 1'b0, 32'hffff},
    '{1'b1, 16'h0630, 32'h6, 1'b0, 32'h6},
    '{1'b1, 16'h0630, 32'h5, 1'b1, 32'h6},
    '{1'b1, 16'h0630, 32'h7, 1'b0, 32'h7},
    '{1'b1, 16'h0624, 32'hc7, 1'b1, 32'h1770},
    '{1'b1, 16'h0624, 32'hc8, 1'b0, 32'hc8},
    '{1'b1, 16'h0624, 32'h2dc6c1, 1'b1, 32'hc8},
    '{1'b1, 16'h0624, 32'h2dc6c0, 1'b0, 32'h2dc6c0},
    '{1'b1, 16'h110a, 32'hc1, 1'b1, 32'hc0},
    '{1'b1, 16'h110a, 32'h80, 1'b0, 32'h80},
    '{1'b1, 16'h110c, 32'h40, 1'b0, 32'h40},
    '{1'b1, 16'h0600, 32'h1, 1'b1, 32'h0}
  };
  logic [15:0] qcode [4] = '{16'hfffe, 16'hffff, 16'h0006, 16'h0007};

  logic        i_clk, i_rst, i_ce, i_halt_in, i_halt_in_en, i_err_valid;
  logic        i_qs_leave, i_fault_reset, i_profile_mode, i_standstill;
  logic        i_move_start, par_wr, par_rd, fb_halt, fb_qstop;
  logic        o_par_ack, o_par_err, o_decel_active, o_decel_use_ramp;
  logic        o_halt_active, o_qs_active, o_resume, p_ack, p_err, ramp;
  logic [2:0]  i_err_class;
  logic [3:0]  o_op_state;
  logic [15:0] par_addr, o_current_limit, code, motor_imax;
  logic [31:0] par_wdata, o_par_rdata, o_decel_value, p_rd, profile_decel;
  int          n_mismatch = 0;
  int          n_tests = 0;

  hqd_stop_select u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_par_wr(par_wr),
    .i_par_rd(par_rd), .i_par_addr(par_addr), .i_par_wdata(par_wdata),
    .o_par_rdata(o_par_rdata), .o_par_ack(o_par_ack),
    .o_par_err(o_par_err), .i_halt_in(i_halt_in),
    .i_halt_in_en(i_halt_in_en), .i_fb_halt(fb_halt),
    .i_fb_qstop(fb_qstop), .i_err_valid(i_err_valid),
    .i_err_class(i_err_class), .i_qs_leave(i_qs_leave),
    .i_fault_reset(i_fault_reset), .i_profile_mode(i_profile_mode),
    .i_standstill(i_standstill), .i_move_start(i_move_start),
    .i_profile_decel(profile_decel), .i_motor_imax(motor_imax),
    .i_stage_imax(16'h00c0), .o_decel_active(o_decel_active),
    .o_decel_use_ramp(o_decel_use_ramp), .o_decel_value(o_decel_value),
    .o_current_limit(o_current_limit), .o_halt_active(o_halt_active),
    .o_qs_active(o_qs_active), .o_resume(o_resume),
    .o_op_state(o_op_state));

  hqd_fb_master u_master (
    .i_clk(i_clk), .i_par_ack(o_par_ack), .i_par_err(o_par_err),
    .i_par_rdata(o_par_rdata), .o_par_wr(par_wr), .o_par_rd(par_rd),
    .o_par_addr(par_addr), .o_par_wdata(par_wdata), .o_fb_halt(fb_halt),
    .o_fb_qstop(fb_qstop));

  // Clock source
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  task automatic par(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    u_master.access(w, a, d, p_ack, p_err, p_rd);
    check({31'h0, p_ack}, 32'h1);
  endtask : par

  task automatic stop_test();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Watchdog
  initial begin
    #100us;
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    {i_rst, i_ce} = 2'b11;
    {i_halt_in, i_halt_in_en, i_err_valid, i_qs_leave} = 4'h0;
    {i_fault_reset, i_profile_mode, i_standstill, i_move_start} = 4'h0;
    i_err_class = 3'h0;
    profile_decel = 32'h00000bb8;
    motor_imax    = 16'h0100;
    tick(20);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        par(1'b1, rows[i].a, rows[i].d);
        check({31'h0, p_err}, {31'h0, rows[i].e});
      end
      par(1'b0, rows[i].a, 32'h0);
      check(p_rd, rows[i].rb);
    end
    $display("test parameters done");
    for (int i = 0; i < 4; i++) begin
      code = i[0] ? 16'h0003 : 16'h0001;
      par(1'b1, 16'h062e, {16'h0, code});
      @(posedge i_clk);
      i_profile_mode <= i[1];
      i_halt_in_en   <= 1'b1;
      i_halt_in      <= (i == 3);
      if (i != 3) u_master.set_halt(1'b1);
      tick(4);
      ramp = (code == 16'h0001) && i[1];
      check({31'h0, o_halt_active}, 32'h1);
      check({31'h0, o_decel_use_ramp}, {31'h0, ramp});
      if (ramp) check(o_decel_value, 32'h00000bb8);
      else check({16'h0, o_current_limit}, 32'h40);
      if (i == 3) begin
        par(1'b1, 16'h062e, 32'h1);
        tick(2);
        check({31'h0, o_decel_use_ramp}, 32'h1);
      end
      @(posedge i_clk);
      i_halt_in <= 1'b0;
      u_master.set_halt(1'b0);
      tick(3);
      check({31'h0, o_decel_active}, 32'h1);
      i_standstill <= 1'b1;
      for (int k = 0; k < 8 && o_resume !== 1'b1; k++) @(posedge i_clk);
      check({31'h0, o_resume}, 32'h1);
      i_standstill <= 1'b0;
      tick(3);
      check({31'h0, o_halt_active}, 32'h0);
    end
    $display("test halt done");
    i_err_valid <= 1'b1;
    i_err_class <= 3'h3;
    @(posedge i_clk);
    i_err_valid <= 1'b0;
    tick(3);
    check({31'h0, o_qs_active}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      par(1'b1, 16'h0630, {16'h0, qcode[i]});
      @(posedge i_clk);
      i_move_start <= (i == 2);
      @(posedge i_clk);
      i_move_start <= 1'b0;
      if (i == 0 || i == 3) u_master.quick_stop();
      else begin
        @(posedge i_clk);
        i_err_valid <= 1'b1;
        i_err_class <= 3'(i);
        @(posedge i_clk);
        i_err_valid <= 1'b0;
      end
      tick(3);
      ramp = (i == 1 || i == 2);
      check({31'h0, o_qs_active}, 32'h1);
      check({31'h0, o_decel_use_ramp}, {31'h0, ramp});
      if (ramp) check(o_decel_value, i == 1 ? 32'h1770 : 32'h2dc6c0);
      else check({16'h0, o_current_limit}, 32'h80);
      i_standstill <= 1'b1;
      tick(3);
      check({28'h0, o_op_state}, i < 2 ? 32'h9 : 32'h7);
      i_standstill  <= 1'b0;
      i_fault_reset <= (i < 2);
      i_qs_leave    <= (i >= 2);
      @(posedge i_clk);
      {i_fault_reset, i_qs_leave} <= 2'b00;
      tick(3);
      check({28'h0, o_op_state}, 32'h0);
    end
    $display("test quick stop done");
    u_master.set_halt(1'b1);
    tick(4);
    u_master.quick_stop();
    tick(2);
    check({31'h0, o_qs_active}, 32'h1);
    check({31'h0, o_halt_active}, 32'h0);
    $display("test override done");
    // Enable low freezes the sequencer even at standstill
    i_ce         <= 1'b0;
    i_standstill <= 1'b1;
    tick(3);
    check({28'h0, o_op_state}, 32'h0);
    i_ce <= 1'b1;
    tick(3);
    check({28'h0, o_op_state}, 32'h7);
    // Lower motor ceiling clamps the stored quick stop current
    i_standstill <= 1'b0;
    motor_imax   <= 16'h0060;
    tick(3);
    par(1'b0, 16'h110a, 32'h0);
    check(p_rd, 32'h60);
    par(1'b0, 16'h110c, 32'h0);
    check(p_rd, 32'h40);
    $display("test enable and ceiling done");
    stop_test();
  end
endmodule : hqd_stop_select_tb
`default_nettype wire
